/* File: hdl/prmi_regs.sv */
// mode, identity and error-correction registers with deep sleep control
`timescale 1ns/1ns
`include "prmi_map.svh"
module prmi_regs
  import prmi_pkg::*;
#(
  parameter logic [2:0] VOLT_CLASS = 3'h0,  // 000 low supply, 001 high supply
  parameter int         ROW_BITS   = 14,    // row address bit count
  parameter int         COL_BITS   = 10,    // column address bit count
  parameter logic [3:0] MAKER_CODE = 4'h5,  // arbitrary value
  parameter int         ENTRY_CYC  = `PRMI_ENTRY_CYC,
  parameter int         EXIT_CYC   = `PRMI_EXIT_CYC,
  parameter int         WAKE_CYC   = `PRMI_WAKE_CYC,
  parameter int         CNT_W      = 12
)(
  input  wire logic             clock,      // system clock, 25 MHz
  input  wire logic             rst_n,      // async reset, active low
  input  wire logic             csPin_n,    // chip select pin, active low
  input  wire prmi_reg_req_type regReq,     // register access from link logic
  input  wire prmi_ecc_evt_type eccEvt,     // correction events, next-cycle word
  input  wire prmi_rd_slot_type rdSlot,     // read slot plan, next cycle
  output logic [15:0]           regRdata,   // register read data
  output logic                  regRvalid,  // read data valid pulse
  output logic [15:0]           cfgWord,    // config word to neighbours
  output logic                  eccEnable,  // correction enabled
  output logic                  deepSleep,  // in any deep sleep phase
  output logic                  lowPower,   // at low-power level
  output logic                  linkReady,  // accesses accepted
  output logic                  arrayLost,  // pulse: stored data now undefined
  output logic                  strobeOut,  // strobe pin output
  output logic                  strobeOe,   // strobe pin drive enable
  output logic                  errOut      // error event pin
);

  localparam logic [15:0] ID_WORD = {VOLT_CLASS, 5'(ROW_BITS - 1), 4'(COL_BITS - 1),
                                     MAKER_CODE};

  prmi_state_type   state;
  prmi_state_type   next_state;
  logic [CNT_W-1:0] phaseCnt;
  logic             csMeta;
  logic             csSync;
  logic [15:0]      eccCtl;
  logic             hist1;
  logic             hist2;
  logic             errFlag;
  logic             cfgWr;
  logic             eccWr;
  logic             clrHit;
  logic             sleepCmd;
  logic             evtHit;
  logic [15:0]      next_ecc;
  logic             next_hist1;
  logic             next_hist2;
  logic             next_err;

  function automatic logic type_match(input logic [1:0] sel, input prmi_ecc_evt_type e);
    case (sel)
      `PRMI_TYPE_SINGLE: type_match = e.single;
      `PRMI_TYPE_DOUBLE: type_match = e.double;
      `PRMI_TYPE_ANY:    type_match = e.single | e.double;
      default:           type_match = 1'b0;
    endcase
  endfunction

  // chip select pin synchroniser
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      csMeta <= 1'b1;
      csSync <= 1'b1;
    end else begin
      csMeta <= csPin_n;
      csSync <= csMeta;
    end
  end

  assign cfgWr    = regReq.wr && (regReq.sel == `PRMI_SEL_CFG) && (state == ST_ACTIVE);
  assign eccWr    = regReq.wr && (regReq.sel == `PRMI_SEL_ECC) && (state == ST_ACTIVE);
  assign sleepCmd = cfgWr && !regReq.wdata[`PRMI_CFG_SLEEP_BIT];
  assign clrHit   = eccWr && regReq.wdata[`PRMI_ECC_CLR_BIT];

  // deep sleep sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_ACTIVE: begin
        if (sleepCmd) begin
          next_state = ST_ENTER;
        end
      end
      ST_ENTER: begin
        if (phaseCnt == CNT_W'(ENTRY_CYC - 1)) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!csSync) begin
          next_state = ST_EXIT;
        end
      end
      ST_EXIT: begin
        if (csSync) begin
          next_state = (phaseCnt >= CNT_W'(EXIT_CYC)) ? ST_WAKE : ST_SLEEP;
        end
      end
      ST_WAKE: begin
        // pin sync and exit decision already used three cycles of the budget
        if (phaseCnt == CNT_W'(WAKE_CYC - 4)) begin
          next_state = ST_ACTIVE;
        end
      end
      default: next_state = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  // phase timer; restarts on each state change, counts low cycles in exit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phaseCnt <= '0;
    end else if (next_state != state) begin
      phaseCnt <= (next_state == ST_EXIT) ? CNT_W'(1) : '0;
    end else if (phaseCnt != '1) begin
      phaseCnt <= phaseCnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      deepSleep <= 1'b0;
      lowPower  <= 1'b0;
      linkReady <= 1'b1;
      arrayLost <= 1'b0;
    end else begin
      deepSleep <= next_state != ST_ACTIVE;
      lowPower  <= (next_state == ST_SLEEP) || (next_state == ST_EXIT);
      linkReady <= next_state == ST_ACTIVE;
      arrayLost <= (state == ST_WAKE) && (next_state == ST_ACTIVE);
    end
  end

  // config word; bit 15 shows 0 from the clearing write until wakeup ends
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfgWord <= `PRMI_CFG_RESET;
    end else if (cfgWr) begin
      cfgWord <= regReq.wdata & ~`PRMI_CFG_RSVD_MASK;
    end else if ((state == ST_WAKE) && (next_state == ST_ACTIVE)) begin
      cfgWord[`PRMI_CFG_SLEEP_BIT] <= 1'b1;
    end
  end

  // error register control fields
  always_comb begin
    next_ecc = eccCtl;
    if (eccWr) begin
      next_ecc = {regReq.wdata[15:12], 12'h000};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      eccCtl <= `PRMI_ECC_RESET;
    end else begin
      eccCtl <= next_ecc;
    end
  end

  assign eccEnable = eccCtl[`PRMI_ECC_ON_BIT];
  assign evtHit    = eccEnable && type_match(eccCtl[13:12], eccEvt);

  // history and sticky error flag; a new event wins over a clear
  always_comb begin
    next_hist1 = hist1;
    next_hist2 = hist2;
    next_err   = errFlag;
    if (clrHit) begin
      next_hist1 = 1'b0;
      next_hist2 = 1'b0;
      next_err   = 1'b0;
    end
    if (eccEnable && eccEvt.single) begin
      next_hist1 = 1'b1;
    end
    if (eccEnable && eccEvt.double) begin
      next_hist2 = 1'b1;
    end
    if (evtHit) begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hist1   <= 1'b0;
      hist2   <= 1'b0;
      errFlag <= 1'b0;
    end else begin
      hist1   <= next_hist1;
      hist2   <= next_hist2;
      errFlag <= next_err;
    end
  end

  // pin rises with the event's word, gated by both enables
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      errOut <= 1'b0;
    end else begin
      errOut <= next_err && next_ecc[`PRMI_ECC_ON_BIT] && next_ecc[`PRMI_ECC_ERREN_BIT];
    end
  end

  // register read port, answered one cycle after the request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regRdata  <= 16'h0000;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regReq.rd && (state == ST_ACTIVE);
      if (regReq.rd && (state == ST_ACTIVE)) begin
        case (regReq.sel)
          `PRMI_SEL_CFG: regRdata <= cfgWord;
          `PRMI_SEL_ID:  regRdata <= ID_WORD;
          `PRMI_SEL_ECC: regRdata <= {eccCtl[15:12], hist1, hist2, 10'h000};
          default:       regRdata <= 16'h0000;
        endcase
      end
    end
  end

  prmi_strobe_gen u_strobe (
    .clock     (clock),
    .rst_n     (rst_n),
    .slot      (rdSlot),
    .preEnable (cfgWord[`PRMI_CFG_PRE_BIT]),
    .strobeOut (strobeOut),
    .strobeOe  (strobeOe)
  );

  // helper counters and registered select read only by assertions
  logic [CNT_W-1:0] aEnterAge;
  logic [CNT_W-1:0] aWakeAge;
  logic [1:0]       aSelQ;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aEnterAge <= '0;
      aWakeAge  <= '0;
      aSelQ     <= 2'h0;
    end else begin
      aEnterAge <= (state == ST_ENTER) ? aEnterAge + CNT_W'(1) : '0;
      aWakeAge  <= (state == ST_WAKE) ? aWakeAge + CNT_W'(1) : '0;
      aSelQ     <= regReq.sel;
    end
  end

  property p_enter_cmd;
    @(posedge clock) disable iff (!rst_n)
      sleepCmd |=> (state == ST_ENTER) && !cfgWord[`PRMI_CFG_SLEEP_BIT] ##1 deepSleep;
  endproperty
  a_enter_cmd: assert property (p_enter_cmd) else $error("sleep write not taken");

  property p_entry_time;
    @(posedge clock) disable iff (!rst_n)
      $rose(lowPower) |-> $past(aEnterAge) == CNT_W'(ENTRY_CYC - 1);
  endproperty
  a_entry_time: assert property (p_entry_time) else $error("low power reached early");

  property p_short_pulse;
    @(posedge clock) disable iff (!rst_n)
      (state == ST_EXIT) && csSync && (phaseCnt < CNT_W'(EXIT_CYC)) |=> state == ST_SLEEP;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse woke device");

  property p_wake_bound;
    @(posedge clock) disable iff (!rst_n)
      aWakeAge <= CNT_W'(WAKE_CYC - 3);
  endproperty
  a_wake_bound: assert property (p_wake_bound) else $error("wakeup too long");

  property p_no_access;
    @(posedge clock) disable iff (!rst_n)
      regReq.rd && !linkReady |=> !regRvalid;
  endproperty
  a_no_access: assert property (p_no_access) else $error("access taken while asleep");

  property p_lost;
    @(posedge clock) disable iff (!rst_n)
      $fell(deepSleep) |-> arrayLost && linkReady;
  endproperty
  a_lost: assert property (p_lost) else $error("array loss not reported");

  property p_id;
    @(posedge clock) disable iff (!rst_n)
      regRvalid && (aSelQ == `PRMI_SEL_ID) |-> regRdata == ID_WORD;
  endproperty
  a_id: assert property (p_id) else $error("identity word changed");

  property p_err_gate;
    @(posedge clock) disable iff (!rst_n)
      errOut |-> eccCtl[`PRMI_ECC_ON_BIT] && eccCtl[`PRMI_ECC_ERREN_BIT];
  endproperty
  a_err_gate: assert property (p_err_gate) else $error("error pin with correction off");

  property p_err_fast;
    @(posedge clock) disable iff (!rst_n)
      evtHit && next_ecc[`PRMI_ECC_ERREN_BIT] && next_ecc[`PRMI_ECC_ON_BIT] |=> errOut;
  endproperty
  a_err_fast: assert property (p_err_fast) else $error("error pin late");

  property p_err_hold;
    @(posedge clock) disable iff (!rst_n)
      $fell(errOut) |-> $past(clrHit) || !(eccCtl[15] && eccCtl[14]);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error pin dropped");

  property p_clear;
    @(posedge clock) disable iff (!rst_n)
      clrHit && !eccEvt.single && !eccEvt.double |=> !hist1 && !hist2 && !errOut;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left history");

  property p_ecc_read;
    @(posedge clock) disable iff (!rst_n)
      regRvalid && (aSelQ == `PRMI_SEL_ECC) |-> regRdata[9:0] == 10'h000;
  endproperty
  a_ecc_read: assert property (p_ecc_read) else $error("reserved bits not zero");

  property p_cov_sleep;
    @(posedge clock) disable iff (!rst_n)
      $rose(lowPower);
  endproperty
  c_cov_sleep: cover property (p_cov_sleep);

  property p_cov_wake;
    @(posedge clock) disable iff (!rst_n)
      arrayLost;
  endproperty
  c_cov_wake: cover property (p_cov_wake);

  property p_cov_err;
    @(posedge clock) disable iff (!rst_n)
      $rose(errOut) ##[1:20] clrHit;
  endproperty
  c_cov_err: cover property (p_cov_err);

endmodule

/* File: hdl/prmi_map.svh */
// register selects, field positions, reset values and timing counts
`ifndef PRMI_MAP_SVH
`define PRMI_MAP_SVH

`define PRMI_SEL_CFG        2'h0
`define PRMI_SEL_ID         2'h1
`define PRMI_SEL_ECC        2'h2

`define PRMI_CFG_SLEEP_BIT  15
`define PRMI_CFG_PRE_BIT    8
`define PRMI_CFG_RSVD_MASK  16'h0E04
`define PRMI_CFG_RESET      16'hF052

`define PRMI_ECC_ON_BIT     15
`define PRMI_ECC_ERREN_BIT  14
`define PRMI_ECC_TYPE_HI    13
`define PRMI_ECC_TYPE_LO    12
`define PRMI_ECC_HIST1_BIT  11
`define PRMI_ECC_HIST2_BIT  10
`define PRMI_ECC_CLR_BIT    9
`define PRMI_ECC_RESET      16'hE000

`define PRMI_TYPE_SINGLE    2'h0
`define PRMI_TYPE_DOUBLE    2'h1
`define PRMI_TYPE_ANY       2'h2

`define PRMI_CLK_MHZ        25
`define PRMI_ENTRY_US       150
`define PRMI_EXIT_NS        200
`define PRMI_WAKE_US        150
`define PRMI_ENTRY_CYC      (`PRMI_ENTRY_US * `PRMI_CLK_MHZ)
`define PRMI_EXIT_CYC       ((`PRMI_EXIT_NS * `PRMI_CLK_MHZ + 999) / 1000)
`define PRMI_WAKE_CYC       (`PRMI_WAKE_US * `PRMI_CLK_MHZ)

`endif

/* File: hdl/prmi_pkg.sv */
// shared types of the mode, identity and error-correction registers
package prmi_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [1:0]  sel;
    logic [15:0] wdata;
  } prmi_reg_req_type;

  typedef struct packed {
    logic single;
    logic double;
  } prmi_ecc_evt_type;

  typedef struct packed {
    logic burst;
    logic preSlot;
    logic dataSlot;
  } prmi_rd_slot_type;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_ENTER  = 3'b001,
    ST_SLEEP  = 3'b010,
    ST_EXIT   = 3'b011,
    ST_WAKE   = 3'b100
  } prmi_state_type;

endpackage

/* File: hdl/prmi_strobe_gen.sv */
// read strobe generator with optional dummy pre-cycle
`timescale 1ns/1ns
module prmi_strobe_gen
  import prmi_pkg::*;
(
  input  wire logic             clock,     // system clock
  input  wire logic             rst_n,     // async reset, active low
  input  wire prmi_rd_slot_type slot,      // next-cycle read slot plan
  input  wire logic             preEnable, // dummy pre-cycle selected
  output logic                  strobeOut, // strobe pin output
  output logic                  strobeOe   // strobe pin drive enable
);

  logic active;

  assign active = slot.dataSlot | (slot.preSlot & preEnable);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strobeOut <= 1'b0;
    end else if (active) begin
      strobeOut <= ~strobeOut;
    end else begin
      strobeOut <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strobeOe <= 1'b0;
    end else begin
      strobeOe <= slot.burst;
    end
  end

  property p_no_pre;
    @(posedge clock) disable iff (!rst_n)
      slot.preSlot && !preEnable && !slot.dataSlot |=> !strobeOut;
  endproperty
  a_no_pre: assert property (p_no_pre) else $error("strobe toggled in pre-cycle");

  property p_pre;
    @(posedge clock) disable iff (!rst_n)
      slot.preSlot && preEnable && !strobeOut |=> strobeOut;
  endproperty
  a_pre: assert property (p_pre) else $error("dummy pre-cycle strobe missing");

  property p_drive;
    @(posedge clock) disable iff (!rst_n)
      slot.burst |=> strobeOe;
  endproperty
  a_drive: assert property (p_drive) else $error("strobe not driven during read");

  property p_cov_pre;
    @(posedge clock) disable iff (!rst_n)
      slot.preSlot && preEnable ##1 slot.dataSlot;
  endproperty
  c_cov_pre: cover property (p_cov_pre);

endmodule

/* File: test/prmi_host_model.sv */
// host controller model: register port, chip select and read slot plan
`timescale 1ns/1ns
module prmi_host_model
  import prmi_pkg::*;
(
  input  wire logic        clock,     // system clock
  input  wire logic [15:0] regRdata,  // read data from device
  input  wire logic        regRvalid, // read valid pulse from device
  output prmi_reg_req_type regReq,    // register access request
  output logic             csPin_n,   // chip select, active low
  output prmi_rd_slot_type rdSlot     // next-cycle read slot plan
);
  // no strobe drive here: the device owns that line during reads
  initial begin
    regReq = '0;
    csPin_n = 1'b1;
    rdSlot = '0;
  end

  // one access, raised and dropped at falling edges; answer taken one cycle on
  task automatic access(input logic wr, input logic [1:0] sel, input logic [15:0] d,
                        output logic v, output logic [15:0] q);
    @(negedge clock);
    regReq = {wr, ~wr, sel, d};
    @(negedge clock);
    v = regRvalid;
    q = regRdata;
    regReq.wr = 1'b0;
    regReq.rd = 1'b0;
    regReq.wdata = ~d;
  endtask

  // chip select low pulse to leave deep sleep
  task automatic wake(input int lowCycles);
    @(negedge clock);
    csPin_n = 1'b0;
    repeat (lowCycles) @(negedge clock);
    csPin_n = 1'b1;
  endtask

  // one slot of plan; returns once the answering edge has settled
  task automatic slot(input prmi_rd_slot_type s);
    @(negedge clock);
    rdSlot = s;
    @(posedge clock);
    #1;
  endtask
endmodule

/* File: test/prmi_regs_bench.sv */
// self-checking bench for the mode, identity and error-correction registers
`timescale 1ns/1ns
`include "prmi_map.svh"
module prmi_regs_bench;
  import prmi_pkg::*;
  localparam int         ROWS  = 14;
  localparam int         COLS  = 10;
  localparam logic [3:0] MAKER = 4'hA; // arbitrary value
  localparam int         ENTRY = 20;
  localparam int         EXIT  = 5;
  localparam int         WAKE  = 20;
  localparam logic [15:0] ID_EXP = {3'h0, 5'h0D, 4'h9, MAKER};
  logic             clock, rst_n, csPin_n, regRvalid, eccEnable, deepSleep;
  logic             lowPower, linkReady, arrayLost, strobeOut, strobeOe, errOut;
  logic [15:0]      regRdata, cfgWord, q, cfgW;
  prmi_reg_req_type regReq;
  prmi_ecc_evt_type eccEvt;
  prmi_rd_slot_type rdSlot, s;
  logic             v, h1, h2, flag, sExp, prev;
  logic [3:0]       eccCtl;
  logic [3:0]       ctlList [5] = '{4'hC, 4'hD, 4'hE, 4'hA, 4'h6};
  int               errCount, checksDone, cyc;

  prmi_regs #(.VOLT_CLASS(3'h0), .ROW_BITS(ROWS), .COL_BITS(COLS), .MAKER_CODE(MAKER),
    .ENTRY_CYC(ENTRY), .EXIT_CYC(EXIT), .WAKE_CYC(WAKE), .CNT_W(12)) prmi_regs_i (
    .clock(clock), .rst_n(rst_n), .csPin_n(csPin_n), .regReq(regReq), .eccEvt(eccEvt),
    .rdSlot(rdSlot), .regRdata(regRdata), .regRvalid(regRvalid), .cfgWord(cfgWord),
    .eccEnable(eccEnable), .deepSleep(deepSleep), .lowPower(lowPower),
    .linkReady(linkReady), .arrayLost(arrayLost), .strobeOut(strobeOut),
    .strobeOe(strobeOe), .errOut(errOut));

  prmi_host_model prmi_host_model_i (
    .clock(clock), .regRdata(regRdata), .regRvalid(regRvalid), .regReq(regReq),
    .csPin_n(csPin_n), .rdSlot(rdSlot));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic finalReport();
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bound(input int n);
    if (n >= 200) begin
      errCount++;
      $display("MISMATCH wait limit expected 1 seen 0");
      finalReport();
    end
  endtask

  task automatic regWr(input logic [1:0] sel, input logic [15:0] d);
    prmi_host_model_i.access(1'b1, sel, d, v, q);
  endtask

  task automatic regRd(input logic [1:0] sel, input logic [15:0] exp, input string name);
    prmi_host_model_i.access(1'b0, sel, 16'h0000, v, q);
    check({name, " valid"}, 16'(v), 16'h0001);
    check(name, q, exp);
  endtask

  // event pulse one cycle ahead of its word; model updated, then pin compared
  task automatic fire(input logic sg, input logic db);
    @(negedge clock);
    eccEvt = {sg, db};
    @(negedge clock);
    eccEvt = '0;
    if (eccCtl[3]) begin
      h1 = h1 | sg;
      h2 = h2 | db;
      case (eccCtl[1:0])
        2'h0: flag = flag | sg;
        2'h1: flag = flag | db;
        2'h2: flag = flag | sg | db;
        default: flag = flag;
      endcase
    end
    check("error pin", 16'(errOut), 16'(flag & eccCtl[3] & eccCtl[2]));
  endtask

  initial begin
    rst_n = 1'b0;
    eccEvt = '0;
    errCount = 0;
    checksDone = 0;
    {h1, h2, flag} = 3'b000;
    void'($urandom(32'hF4C5CC5E));
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    regRd(`PRMI_SEL_CFG, 16'hF052, "config");
    regRd(`PRMI_SEL_ID, ID_EXP, "identity");
    regWr(`PRMI_SEL_ID, 16'hFFFF);
    regRd(`PRMI_SEL_ID, ID_EXP, "identity kept");
    regRd(`PRMI_SEL_ECC, 16'hE000, "ecc reset");
    $display("reset and identity test done");

    foreach (ctlList[i]) begin
      eccCtl = ctlList[i];
      regWr(`PRMI_SEL_ECC, {eccCtl, 12'h000});
      check("ecc enable", 16'(eccEnable), 16'(eccCtl[3]));
      fire(1'b1, 1'b1);
      for (int k = 0; k < 6; k++) fire(1'($urandom), 1'($urandom));
      regRd(`PRMI_SEL_ECC, {eccCtl, h1, h2, 10'h000}, "history");
      regWr(`PRMI_SEL_ECC, {eccCtl, 12'h200});
      {h1, h2, flag} = 3'b000;
      check("error pin cleared", 16'(errOut), 16'h0000);
      regRd(`PRMI_SEL_ECC, {eccCtl, 12'h000}, "history cleared");
    end
    eccCtl = 4'hE;
    regWr(`PRMI_SEL_ECC, 16'hE000);
    $display("error correction test done");

    for (int p = 0; p < 2; p++) begin
      cfgW = 16'hFE56 | 16'(p << 8);
      regWr(`PRMI_SEL_CFG, cfgW);
      check("config write", cfgWord, cfgW & ~16'h0E04);
      prev = 1'b0;
      for (int c = 0; c < 7; c++) begin
        s = {c < 6, c == 0, c > 0 && c < 6};
        prmi_host_model_i.slot(s);
        sExp = s.preSlot ? 1'(p) : (s.dataSlot ? ~prev : 1'b0);
        check("strobe", 16'(strobeOut), 16'(sExp));
        check("strobe drive", 16'(strobeOe), 16'(s.burst));
        prev = sExp;
      end
    end
    $display("strobe test done");

    regWr(`PRMI_SEL_CFG, 16'h7052);
    cyc = 0;
    while (lowPower !== 1'b1 && cyc < 200) begin
      @(negedge clock);
      cyc++;
    end
    bound(cyc);
    check("entry time", 16'(cyc >= ENTRY && cyc <= ENTRY + 2), 16'h0001);
    check("asleep", 16'(deepSleep & ~linkReady), 16'h0001);
    prmi_host_model_i.access(1'b0, `PRMI_SEL_CFG, 16'h0000, v, q);
    check("refused read", 16'(v), 16'h0000);
    prmi_host_model_i.wake(EXIT - 3);
    repeat (4) @(negedge clock);
    check("short pulse", 16'(lowPower), 16'h0001);
    prmi_host_model_i.wake(EXIT + 2);
    cyc = 0;
    while (linkReady !== 1'b1 && cyc < 200) begin
      @(negedge clock);
      cyc++;
    end
    bound(cyc);
    check("wake time", 16'(cyc == WAKE), 16'h0001);
    check("array lost", 16'(arrayLost), 16'h0001);
    check("sleep bit back", 16'(cfgWord[15]), 16'h0001);
    @(negedge clock);
    check("array lost pulse", 16'(arrayLost), 16'h0000);
    check("awake", 16'(deepSleep), 16'h0000);
    regRd(`PRMI_SEL_ID, ID_EXP, "identity after wake");
    $display("deep sleep test done");
    finalReport();
  end
endmodule
